// ---- verilog/mic_regs.vh ----
// register offsets, field positions, vectors and reset values of the interrupt controller
`ifndef MIC_REGS_VH
`define MIC_REGS_VH

// ==========================================================================
// data memory addresses
`define MIC_ADDR_CTRL_LOW     7'h0B
`define MIC_ADDR_CTRL_HIGH    7'h1E

// ==========================================================================
// irq_ctrl_low fields
`define MIC_BIT_GLOBAL_EN     0
`define MIC_BIT_EXT_A_EN      1
`define MIC_BIT_EXT_B_EN      2
`define MIC_BIT_TIMER_EN      3
`define MIC_BIT_EXT_A_PEND    4
`define MIC_BIT_EXT_B_PEND    5
`define MIC_BIT_TIMER_PEND    6

// ==========================================================================
// irq_ctrl_high fields
`define MIC_BIT_TICK_EN       0
`define MIC_BIT_CLOCK_EN      1
`define MIC_BIT_TICK_PEND     4
`define MIC_BIT_CLOCK_PEND    5

// ==========================================================================
// reset values
`define MIC_RESET_CTRL_LOW    8'h00
`define MIC_RESET_CTRL_HIGH   8'h00
`define MIC_RESET_PIN         1'b1

// ==========================================================================
// vectors, 11-bit program addresses
`define MIC_VEC_EXT_A         11'h004
`define MIC_VEC_EXT_B         11'h008
`define MIC_VEC_TIMER         11'h00C
`define MIC_VEC_TICK          11'h010
`define MIC_VEC_CLOCK         11'h014

`endif

// ---- verilog/mic_pin_sync.v ----
// three-stage synchroniser with falling-edge detection for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.vh"

module mic_pin_sync (
  // clock and reset
  input  wire clk_sys_in,
  input  wire reset_n_in,
  // pin level
  input  wire pin_in,
  // one-cycle pulse on a qualified high-to-low transition
  output reg  fall_out
);

  reg stage_1;
  reg stage_2;
  reg stage_3;
  reg level;

  // ==========================================================================
  // synchroniser: a change counts once stage_2 and stage_3 agree
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      stage_1  <= `MIC_RESET_PIN;
      stage_2  <= `MIC_RESET_PIN;
      stage_3  <= `MIC_RESET_PIN;
      level    <= `MIC_RESET_PIN;
      fall_out <= 1'b0;
    end else begin
      stage_1  <= pin_in;
      stage_2  <= stage_1;
      stage_3  <= stage_2;
      fall_out <= 1'b0;
      if (stage_2 == stage_3) begin
        level <= stage_3;
        if (level && !stage_3) begin
          fall_out <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/mic_prio_enc.v ----
// fixed-priority selector of the highest qualified source and its vector
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.vh"

module mic_prio_enc (
  // qualified requests, bit 0 highest priority
  input  wire [4:0]  request_in,
  // one-hot grant and vector
  output reg  [4:0]  grant_out,
  output reg  [10:0] vector_out
);

  // ==========================================================================
  // priority: ext a, ext b, timer, tick, clock
  always @* begin
    grant_out  = 5'h00;
    vector_out = `MIC_VEC_EXT_A;
    if (request_in[0]) begin
      grant_out  = 5'h01;
      vector_out = `MIC_VEC_EXT_A;
    end else if (request_in[1]) begin
      grant_out  = 5'h02;
      vector_out = `MIC_VEC_EXT_B;
    end else if (request_in[2]) begin
      grant_out  = 5'h04;
      vector_out = `MIC_VEC_TIMER;
    end else if (request_in[3]) begin
      grant_out  = 5'h08;
      vector_out = `MIC_VEC_TICK;
    end else if (request_in[4]) begin
      grant_out  = 5'h10;
      vector_out = `MIC_VEC_CLOCK;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/mic_irq_ctrl.v ----
// interrupt controller: pending flags, enables, arbitration and core hand-off
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.vh"

module mic_irq_ctrl (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  // external interrupt pins, active-low edge
  input  wire        ext_irq_pin_a_in,
  input  wire        ext_irq_pin_b_in,
  // internal event pulses
  input  wire        timer_overflow_in,
  input  wire        tick_event_in,
  input  wire        clock_event_in,
  // data memory access
  input  wire [6:0]  mem_addr_in,
  input  wire        mem_write_in,
  input  wire [7:0]  mem_wdata_in,
  output reg  [7:0]  mem_rdata_out,
  // core interface
  input  wire        stack_full_in,
  input  wire        irq_exit_instr_in,
  input  wire        ack_slot_in,
  output reg         irq_take_out,
  output reg  [10:0] irq_vector_out,
  output reg         wake_out
);

  // ==========================================================================
  // control state
  reg  global_irq_enable;
  reg  ext_a_irq_enable;
  reg  ext_b_irq_enable;
  reg  timer_irq_enable;
  reg  tick_irq_enable;
  reg  clock_irq_enable;
  reg  ext_a_pending;
  reg  ext_b_pending;
  reg  timer_pending;
  reg  tick_pending;
  reg  clock_pending;

  wire       fall_a;
  wire       fall_b;
  wire [4:0] grant;
  wire [10:0] vector;
  wire [4:0] qualified;
  wire       take;
  wire       wr_low;
  wire       wr_high;
  wire [7:0] irq_ctrl_low;
  wire [7:0] irq_ctrl_high;

  // ==========================================================================
  // pin edge detectors
  mic_pin_sync u_sync_a (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (ext_irq_pin_a_in),
    .fall_out   (fall_a)
  );

  mic_pin_sync u_sync_b (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (ext_irq_pin_b_in),
    .fall_out   (fall_b)
  );

  // ==========================================================================
  // arbitration
  assign qualified = {clock_pending & clock_irq_enable,
                      tick_pending  & tick_irq_enable,
                      timer_pending & timer_irq_enable,
                      ext_b_pending & ext_b_irq_enable,
                      ext_a_pending & ext_a_irq_enable};

  assign take = ack_slot_in & global_irq_enable & ~stack_full_in
                & (|qualified);

  mic_prio_enc u_prio (
    .request_in (qualified),
    .grant_out  (grant),
    .vector_out (vector)
  );

  // ==========================================================================
  // register image
  assign irq_ctrl_low  = {1'b0, timer_pending, ext_b_pending, ext_a_pending,
                          timer_irq_enable, ext_b_irq_enable, ext_a_irq_enable,
                          global_irq_enable};
  assign irq_ctrl_high = {2'b00, clock_pending, tick_pending, 2'b00,
                          clock_irq_enable, tick_irq_enable};

  assign wr_low  = mem_write_in && (mem_addr_in == `MIC_ADDR_CTRL_LOW);
  assign wr_high = mem_write_in && (mem_addr_in == `MIC_ADDR_CTRL_HIGH);

  // ==========================================================================
  // enables
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      global_irq_enable <= 1'b0;
      ext_a_irq_enable  <= 1'b0;
      ext_b_irq_enable  <= 1'b0;
      timer_irq_enable  <= 1'b0;
      tick_irq_enable   <= 1'b0;
      clock_irq_enable  <= 1'b0;
    end else begin
      if (wr_low) begin
        global_irq_enable <= mem_wdata_in[`MIC_BIT_GLOBAL_EN];
        ext_a_irq_enable  <= mem_wdata_in[`MIC_BIT_EXT_A_EN];
        ext_b_irq_enable  <= mem_wdata_in[`MIC_BIT_EXT_B_EN];
        timer_irq_enable  <= mem_wdata_in[`MIC_BIT_TIMER_EN];
      end
      if (wr_high) begin
        tick_irq_enable  <= mem_wdata_in[`MIC_BIT_TICK_EN];
        clock_irq_enable <= mem_wdata_in[`MIC_BIT_CLOCK_EN];
      end
      if (irq_exit_instr_in) begin
        global_irq_enable <= 1'b1;
      end
      if (take) begin
        global_irq_enable <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pending flags: hardware set wins over clear
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ext_a_pending <= 1'b0;
      ext_b_pending <= 1'b0;
      timer_pending <= 1'b0;
      tick_pending  <= 1'b0;
      clock_pending <= 1'b0;
    end else begin
      if (wr_low) begin
        ext_a_pending <= mem_wdata_in[`MIC_BIT_EXT_A_PEND];
        ext_b_pending <= mem_wdata_in[`MIC_BIT_EXT_B_PEND];
        timer_pending <= mem_wdata_in[`MIC_BIT_TIMER_PEND];
      end
      if (wr_high) begin
        tick_pending  <= mem_wdata_in[`MIC_BIT_TICK_PEND];
        clock_pending <= mem_wdata_in[`MIC_BIT_CLOCK_PEND];
      end
      if (take && grant[0]) begin
        ext_a_pending <= 1'b0;
      end
      if (take && grant[1]) begin
        ext_b_pending <= 1'b0;
      end
      if (take && grant[2]) begin
        timer_pending <= 1'b0;
      end
      if (take && grant[3]) begin
        tick_pending <= 1'b0;
      end
      if (take && grant[4]) begin
        clock_pending <= 1'b0;
      end
      if (fall_a) begin
        ext_a_pending <= 1'b1;
      end
      if (fall_b) begin
        ext_b_pending <= 1'b1;
      end
      if (timer_overflow_in) begin
        timer_pending <= 1'b1;
      end
      if (tick_event_in) begin
        tick_pending <= 1'b1;
      end
      if (clock_event_in) begin
        clock_pending <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // outputs to core
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      irq_take_out   <= 1'b0;
      irq_vector_out <= 11'h000;
      wake_out       <= 1'b0;
      mem_rdata_out  <= 8'h00;
    end else begin
      // core pushes only the program counter, then loads the vector
      irq_take_out <= take;
      if (take) begin
        irq_vector_out <= vector;
      end
      wake_out <= ext_a_pending | ext_b_pending | timer_pending
                  | tick_pending | clock_pending;
      case (mem_addr_in)
        `MIC_ADDR_CTRL_LOW:  mem_rdata_out <= irq_ctrl_low;
        `MIC_ADDR_CTRL_HIGH: mem_rdata_out <= irq_ctrl_high;
        default:             mem_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- test/mic_irq_ctrl_assertions.sv ----
// concurrent checks on the ports of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_assertions (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  // sources
  input wire logic        ext_irq_pin_a_in,
  input wire logic        ext_irq_pin_b_in,
  input wire logic        timer_overflow_in,
  input wire logic        tick_event_in,
  input wire logic        clock_event_in,
  // data memory
  input wire logic [6:0]  mem_addr_in,
  input wire logic        mem_write_in,
  input wire logic [7:0]  mem_wdata_in,
  input wire logic [7:0]  mem_rdata_out,
  // core side
  input wire logic        stack_full_in,
  input wire logic        irq_exit_instr_in,
  input wire logic        ack_slot_in,
  input wire logic        irq_take_out,
  input wire logic [10:0] irq_vector_out,
  input wire logic        wake_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // acknowledge
  AST_ONE_TAKE: assert property (irq_take_out |=> !irq_take_out)
    else $error("take twice in a row");
  AST_FULL_BLOCK: assert property (stack_full_in |=> !irq_take_out)
    else $error("take while stack full");
  AST_SLOT_GATE: assert property (!ack_slot_in |=> !irq_take_out)
    else $error("take without slot");
  AST_VEC_SET: assert property (irq_take_out |-> irq_vector_out inside
    {11'h004, 11'h008, 11'h00C, 11'h010, 11'h014}) else $error("bad vector");
  AST_VEC_HOLD: assert property (!irq_take_out |-> $stable(irq_vector_out))
    else $error("vector moved");
  AST_WAKE_EVT: assert property ((timer_overflow_in || tick_event_in || clock_event_in)
    |-> ##2 wake_out) else $error("no wake");
  // ==========================================================================
  // register reads
  AST_LOW_RSVD: assert property ($past(mem_addr_in) == 7'h0B |-> !mem_rdata_out[7])
    else $error("low bit 7 set");
  AST_HIGH_RSVD: assert property ($past(mem_addr_in) == 7'h1E |->
    (mem_rdata_out & 8'hCC) == 8'h00) else $error("high spare bits set");
  AST_OTHER_ZERO: assert property (!($past(mem_addr_in) inside {7'h0B, 7'h1E})
    |-> mem_rdata_out == 8'h00) else $error("unmapped read not zero");
  cover property (irq_take_out && irq_vector_out == 11'h014);
  cover property (stack_full_in && timer_overflow_in);
  cover property (irq_exit_instr_in ##2 irq_take_out);
endmodule
bind mic_irq_ctrl mic_irq_ctrl_assertions u_mic_irq_ctrl_assertions (.*);
`default_nettype wire

// ---- test/mic_core_model.sv ----
// core side model: return stack depth, acknowledge slot, interrupt return pulse
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  // controller side
  input  wire logic take_in,
  output var  logic full_out,
  output var  logic exit_out,
  output var  logic slot_out,
  // bench commands
  input  wire logic slot_en_in,
  input  wire logic exit_cmd_in
);
  logic [2:0] depth;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      depth <= 3'h0;
      exit_out <= 1'b0;
    end else begin
      exit_out <= exit_cmd_in;
      if (take_in)
        depth <= depth + 3'h1;
      else if (exit_cmd_in && depth != 3'h0)
        depth <= depth - 3'h1;
    end
  end
  assign full_out = (depth == 3'h4);
  assign slot_out = slot_en_in;
endmodule
`default_nettype wire

// ---- test/mic_irq_ctrl_tb.sv ----
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module mic_irq_ctrl_tb;
  logic clk_sys_in, reset_n_in, ext_irq_pin_a_in, ext_irq_pin_b_in;
  logic timer_overflow_in, tick_event_in, clock_event_in, mem_write_in;
  logic [6:0] mem_addr_in;
  logic [7:0] mem_wdata_in, mem_rdata_out;
  logic stack_full_in, irq_exit_instr_in, ack_slot_in, irq_take_out, wake_out;
  logic [10:0] irq_vector_out;
  logic slot_en, exit_cmd;
  int error_cnt, num_checks;
  mic_irq_ctrl u_mic_irq_ctrl (.*);
  mic_core_model u_mic_core_model (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .take_in(irq_take_out), .full_out(stack_full_in), .exit_out(irq_exit_instr_in),
    .slot_out(ack_slot_in), .slot_en_in(slot_en), .exit_cmd_in(exit_cmd));
  always #5 clk_sys_in = ~clk_sys_in;
  // ==========================================================================
  // bus cycles and events
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    {mem_addr_in, mem_wdata_in, mem_write_in} = {a, d, 1'b1};
    @(negedge clk_sys_in);
    mem_write_in = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk_sys_in);
    mem_addr_in = a;
    @(negedge clk_sys_in);
    `CHK(mem_rdata_out, e)
  endtask
  // bit 0 pin a, 1 pin b, 2 timer, 3 tick, 4 clock; pins stay low
  task automatic evt(input logic [4:0] m);
    @(negedge clk_sys_in);
    {clock_event_in, tick_event_in, timer_overflow_in} = m[4:2];
    if (m[0]) ext_irq_pin_a_in = 1'b0;
    if (m[1]) ext_irq_pin_b_in = 1'b0;
    @(negedge clk_sys_in);
    {clock_event_in, tick_event_in, timer_overflow_in} = 3'h0;
  endtask
  task automatic wait_take(input logic [10:0] v);
    for (int i = 0; i < 20 && irq_take_out !== 1'b1; i++) @(negedge clk_sys_in);
    `CHK(irq_take_out, 1'b1)
    `CHK(irq_vector_out, v)
  endtask
  task automatic leave_irq();
    @(negedge clk_sys_in);
    exit_cmd = 1'b1;
    @(negedge clk_sys_in);
    exit_cmd = 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rd(7'h0B, 8'h00);
    rd(7'h1E, 8'h00);
    wr(7'h0B, 8'hFF);
    rd(7'h0B, 8'h7F);
    wr(7'h1E, 8'hFF);
    rd(7'h1E, 8'h33);
    wr(7'h20, 8'hFF);
    rd(7'h20, 8'h00);
    wr(7'h0B, 8'h00);
    wr(7'h1E, 8'h00);
  endtask
  task automatic t_prio();
    logic [10:0] v [4] = '{11'h008, 11'h00C, 11'h010, 11'h014};
    evt(5'h1F);
    repeat (6) @(negedge clk_sys_in);
    {ext_irq_pin_a_in, ext_irq_pin_b_in} = 2'h3;
    rd(7'h0B, 8'h70);
    rd(7'h1E, 8'h30);
    `CHK(wake_out, 1'b1)
    wr(7'h0B, 8'h7F);
    wr(7'h1E, 8'h33);
    slot_en = 1'b1;
    wait_take(11'h004);
    rd(7'h0B, 8'h6E);
    leave_irq();
    for (int i = 0; i < 4; i++) begin
      wait_take(v[i]);
      leave_irq();
    end
    rd(7'h0B, 8'h0F);
    rd(7'h1E, 8'h03);
  endtask
  task automatic t_stack();
    wr(7'h0B, 8'h09);
    for (int i = 0; i < 4; i++) begin
      evt(5'h04);
      wait_take(11'h00C);
      rd(7'h0B, 8'h08);
      wr(7'h0B, 8'h09);
    end
    evt(5'h04);
    repeat (8) @(negedge clk_sys_in);
    rd(7'h0B, 8'h49);
    leave_irq();
    wait_take(11'h00C);
    repeat (4) leave_irq();
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {clk_sys_in, reset_n_in, slot_en, exit_cmd, mem_write_in} = 5'h0;
    {timer_overflow_in, tick_event_in, clock_event_in} = 3'h0;
    {ext_irq_pin_a_in, ext_irq_pin_b_in, mem_addr_in, mem_wdata_in} = {2'h3, 15'h0};
    repeat (3) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    t_regs();
    t_prio();
    t_stack();
    conclude();
  end
  initial begin
    #50000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
